// ---- logic/tkp_filter_prox_top.sv ----
`timescale 1ns/1ps
module tkp_filter_prox_top
    import tkp_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [CH_COUNT*DELTA_W-1:0] channel_delta_in,
    input wire logic [DELTA_W-1:0] touch_level_in,
    input wire logic [DELTA_W-1:0] release_level_in,
    input wire logic prox_sample_valid_in,
    input wire logic [IMP_W-1:0] prox_sample_in,
    output logic prox_enable_out,
    output logic [3:0] prox_channel_out,
    output logic [5:0] dither_factor_out
);
    tkp_regbus_if bus ();

    tkp_i2c_slave u_i2c (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .bus(bus)
    );

    function automatic logic [CH_COUNT-1:0] keep_strongest(input logic [CH_COUNT-1:0] cand,
        input logic [CH_COUNT*DELTA_W-1:0] delta, input logic [1:0] n);
        logic [CH_COUNT-1:0] left;
        logic [CH_COUNT-1:0] keep;
        logic [DELTA_W-1:0] best;
        int bi;
        left = cand;
        keep = '0;
        for (int k = 0; k < 3; k++)
        begin
            best = '0;
            bi = -1;
            for (int c = 0; c < CH_COUNT; c++)
                if (left[c] && (bi < 0 || delta[c*DELTA_W +: DELTA_W] > best))
                begin
                    best = delta[c*DELTA_W +: DELTA_W];
                    bi = c;
                end
            if (k < int'(n) && bi >= 0)
            begin
                keep[bi] = 1'b1;
                left[bi] = 1'b0;
            end
        end
        return keep;
    endfunction

    function automatic logic [4:0] interval_len(input logic [2:0] code);
        // reserved codes fall back to the longest interval
        return (code > INTERVAL_MAX_CODE) ? (INTERVAL_ONE << INTERVAL_MAX_CODE) : (INTERVAL_ONE << code);
    endfunction

    // ========================================
    // realtime touch with hysteresis
    logic [CH_COUNT-1:0] rt_reg, rt_next;
    genvar g;
    generate
        for (g = 0; g < CH_COUNT; g++)
        begin : g_rt
            assign rt_next[g] = rt_reg[g] ? !(channel_delta_in[g*DELTA_W +: DELTA_W] < release_level_in)
                                          : (channel_delta_in[g*DELTA_W +: DELTA_W] > touch_level_in);
        end
    endgenerate

    // ========================================
    // registers and key filter
    logic [7:0] ctrl_reg, ctrl_next, cfg_reg, cfg_next, tthr_reg, tthr_next, env_reg, env_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [CH_COUNT-1:0] mask_reg, mask_next, filt_reg, filt_next;
    logic [IMP_W-1:0] sample_reg, sample_next, cal_reg, cal_next;
    logic [IMP_W-1:0] port_data;
    logic [15:0] port_word;
    logic detect_reg, cal_done_reg;
    logic force_start;

    assign force_start = bus.wr && bus.addr == ADDR_ENV_THR && bus.wdata[ENV_FORCE_BIT] && !env_reg[ENV_FORCE_BIT];
    assign port_data = (cfg_reg[1:0] == ACCESS_DITHERED) ? sample_reg :
                       (cfg_reg[1:0] == ACCESS_CALIBRATED) ? cal_reg : '0;
    assign port_word = {detect_reg, cal_done_reg, 1'b0, port_data};

    always_comb
    begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        cfg_next = cfg_reg;
        tthr_next = tthr_reg;
        env_next = env_reg;
        rdata_next = rdata_reg;
        if (bus.wr)
        begin
            unique case (bus.addr)
                ADDR_CTRL: ctrl_next = bus.wdata & CTRL_WR_MASK;
                ADDR_MASK_LOW: mask_next[7:0] = bus.wdata;
                ADDR_MASK_MID: mask_next[15:8] = bus.wdata;
                ADDR_MASK_HIGH: mask_next[23:16] = bus.wdata;
                ADDR_CFG: cfg_next = bus.wdata & CFG_WR_MASK;
                ADDR_TOUCH_THR: tthr_next = bus.wdata;
                ADDR_ENV_THR: env_next = bus.wdata;
                default:
                begin
                end
            endcase
        end
        if (bus.rd)
        begin
            unique case (bus.addr)
                ADDR_CTRL: rdata_next = ctrl_reg;
                ADDR_MASK_LOW: rdata_next = mask_reg[7:0];
                ADDR_MASK_MID: rdata_next = mask_reg[15:8];
                ADDR_MASK_HIGH: rdata_next = mask_reg[23:16];
                ADDR_CFG: rdata_next = cfg_reg;
                ADDR_TOUCH_THR: rdata_next = tthr_reg;
                ADDR_ENV_THR: rdata_next = env_reg;
                ADDR_FILT0: rdata_next = filt_reg[7:0];
                ADDR_FILT1: rdata_next = filt_reg[15:8];
                ADDR_FILT2: rdata_next = filt_reg[23:16];
                ADDR_PROX_LO: rdata_next = port_word[7:0];
                ADDR_PROX_HI: rdata_next = port_word[15:8];
                ADDR_RT0: rdata_next = rt_reg[7:0];
                ADDR_RT1: rdata_next = rt_reg[15:8];
                ADDR_RT2: rdata_next = rt_reg[23:16];
                default: rdata_next = RESET_BYTE;
            endcase
        end
        // channels outside the group pass straight through
        filt_next = (ctrl_reg[1:0] == FILTER_NONE) ? rt_reg :
                    ((rt_reg & ~mask_reg) | keep_strongest(rt_reg & mask_reg, channel_delta_in, ctrl_reg[1:0]));
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctrl_reg <= RESET_BYTE;
            mask_reg <= '0;
            cfg_reg <= RESET_BYTE;
            tthr_reg <= RESET_BYTE;
            env_reg <= RESET_BYTE;
            rdata_reg <= RESET_BYTE;
            filt_reg <= '0;
            rt_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            cfg_reg <= cfg_next;
            tthr_reg <= tthr_next;
            env_reg <= env_next;
            rdata_reg <= rdata_next;
            filt_reg <= filt_next;
            rt_reg <= rt_next;
        end
    end

    assign bus.rdata = rdata_reg;

    // ========================================
    // proximity engine
    logic [4:0] count_reg, count_next;
    logic cal_valid_reg, cal_valid_next, cal_done_next, busy_reg, busy_next, detect_next;
    logic [IMP_W-1:0] diff;
    logic prox_en;

    assign prox_en = ctrl_reg[CTRL_EN_BIT];
    assign diff = (cal_reg > prox_sample_in) ? cal_reg - prox_sample_in : prox_sample_in - cal_reg;

    always_comb
    begin
        sample_next = sample_reg;
        cal_next = cal_reg;
        count_next = count_reg;
        cal_valid_next = cal_valid_reg;
        cal_done_next = cal_done_reg;
        busy_next = busy_reg;
        detect_next = detect_reg;
        if (busy_reg)
        begin
            cal_next = sample_reg;
            cal_valid_next = 1'b1;
            cal_done_next = 1'b1;
            busy_next = 1'b0;
            count_next = 5'h00;
        end
        else if (!prox_en)
            detect_next = 1'b0;
        else if (prox_sample_valid_in)
        begin
            sample_next = prox_sample_in;
            // impedance falls as a hand approaches
            detect_next = cal_valid_reg && cal_reg > prox_sample_in &&
                          (cal_reg - prox_sample_in) > {5'h00, tthr_reg};
            if (!cal_valid_reg)
            begin
                cal_next = prox_sample_in;
                cal_valid_next = 1'b1;
                cal_done_next = 1'b1;
            end
            else if (count_reg + 5'h01 >= interval_len(cfg_reg[4:2]))
            begin
                count_next = 5'h00;
                if (diff <= {6'h00, env_reg[6:0]})
                    cal_next = prox_sample_in;
                cal_done_next = 1'b1;
            end
            else
                count_next = count_reg + 5'h01;
        end
        // forced copy outranks a periodic completion so status reads zero while pending
        if (force_start)
        begin
            busy_next = 1'b1;
            cal_done_next = 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sample_reg <= '0;
            cal_reg <= '0;
            count_reg <= 5'h00;
            cal_valid_reg <= 1'b0;
            cal_done_reg <= 1'b0;
            busy_reg <= 1'b0;
            detect_reg <= 1'b0;
        end
        else
        begin
            sample_reg <= sample_next;
            cal_reg <= cal_next;
            count_reg <= count_next;
            cal_valid_reg <= cal_valid_next;
            cal_done_reg <= cal_done_next;
            busy_reg <= busy_next;
            detect_reg <= detect_next;
        end
    end

    assign prox_enable_out = prox_en;
    assign prox_channel_out = ctrl_reg[CTRL_SEL_LSB +: 4];
    assign dither_factor_out = DITHER_BASE << cfg_reg[CFG_DITHER_LSB +: 2];

    // ========================================
    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    property p_unmasked_pass;
        !rst_in |=> ((filt_reg & ~$past(mask_reg)) == ($past(rt_reg) & ~$past(mask_reg)));
    endproperty
    a_unmasked_pass: assert property (p_unmasked_pass) else $error("ungrouped channel altered");

    property p_nofilter_pass;
        (ctrl_reg[1:0] == FILTER_NONE) |=> (filt_reg == $past(rt_reg));
    endproperty
    a_nofilter_pass: assert property (p_nofilter_pass) else $error("unfiltered status mismatch");

    property p_filter_limit;
        (ctrl_reg[1:0] != FILTER_NONE) |=> ($countones(filt_reg & $past(mask_reg)) <= $past(ctrl_reg[1:0]));
    endproperty
    a_filter_limit: assert property (p_filter_limit) else $error("too many filtered keys");

    property p_rt_hold;
        (!rt_reg[0] && channel_delta_in[DELTA_W-1:0] <= touch_level_in) |=> !rt_reg[0];
    endproperty
    a_rt_hold: assert property (p_rt_hold) else $error("touch set below level");

    property p_dither_max;
        (cfg_reg[7:6] == 2'h3) |-> (dither_factor_out == 6'h20);
    endproperty
    a_dither_max: assert property (p_dither_max) else $error("dither factor wrong");

    property p_interval;
        (prox_en && prox_sample_valid_in && cal_valid_reg && !busy_reg &&
         count_reg == interval_len(cfg_reg[4:2]) - 5'h01) |=> (count_reg == 5'h00);
    endproperty
    a_interval: assert property (p_interval) else $error("interval count overrun");

    property p_forced_cal;
        force_start |=> !cal_done_reg ##1 (cal_done_reg && cal_reg == $past(sample_reg));
    endproperty
    a_forced_cal: assert property (p_forced_cal) else $error("forced calibration failed");

    property p_port_low;
        (bus.rd && bus.addr == ADDR_PROX_LO && cfg_reg[1:0] == ACCESS_DITHERED) |=> (rdata_reg == $past(sample_reg[7:0]));
    endproperty
    a_port_low: assert property (p_port_low) else $error("port low byte wrong");

    property p_port_high;
        (bus.rd && bus.addr == ADDR_PROX_HI) |=> (rdata_reg[7:6] == $past({detect_reg, cal_done_reg}));
    endproperty
    a_port_high: assert property (p_port_high) else $error("port status bits wrong");

    property p_disabled;
        !prox_en && !busy_reg |=> !detect_reg;
    endproperty
    a_disabled: assert property (p_disabled) else $error("detect while disabled");
endmodule

// ---- logic/tkp_i2c_slave.sv ----
`timescale 1ns/1ps
module tkp_i2c_slave
    import tkp_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR
)
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    tkp_regbus_if.master bus
);
    // ========================================
    // pin synchronisers
    logic [2:0] scl_sync_reg, scl_sync_next;
    logic [2:0] sda_sync_reg, sda_sync_next;
    logic scl, scl_d, sda, sda_d, rise, fall, start, stop;

    always_comb
    begin
        scl_sync_next = {scl_sync_reg[1:0], scl_in};
        sda_sync_next = {sda_sync_reg[1:0], sda_in};
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
        end
        else
        begin
            scl_sync_reg <= scl_sync_next;
            sda_sync_reg <= sda_sync_next;
        end
    end

    assign scl = scl_sync_reg[1];
    assign scl_d = scl_sync_reg[2];
    assign sda = sda_sync_reg[1];
    assign sda_d = sda_sync_reg[2];
    assign rise = scl & ~scl_d;
    assign fall = ~scl & scl_d;
    assign start = scl & scl_d & sda_d & ~sda;
    assign stop = scl & scl_d & ~sda_d & sda;

    // ========================================
    // byte engine
    tkp_i2c_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] ptr_reg, ptr_next;
    logic first_reg, first_next, rw_reg, rw_next, bump_reg, bump_next;
    logic oe_reg, oe_next, wr_reg, wr_next, rd_reg, rd_next;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        first_next = first_reg;
        rw_next = rw_reg;
        bump_next = bump_reg;
        oe_next = oe_reg;
        wr_next = 1'b0;
        rd_next = 1'b0;
        if (stop)
        begin
            state_next = TKP_IDLE;
            oe_next = 1'b0;
        end
        else if (start)
        begin
            state_next = TKP_ADDR;
            cnt_next = 4'h0;
            first_next = 1'b1;
            bump_next = 1'b0;
            oe_next = 1'b0;
        end
        else
        begin
            unique case (state_reg)
                TKP_IDLE:
                begin
                end
                TKP_ADDR, TKP_WRITE:
                begin
                    if (rise)
                    begin
                        shift_next = {shift_reg[6:0], sda};
                        cnt_next = cnt_reg + 4'h1;
                    end
                    else if (fall && cnt_reg == 4'h8)
                    begin
                        state_next = TKP_ACK;
                        oe_next = 1'b1;
                        if (state_reg == TKP_ADDR)
                        begin
                            rw_next = shift_reg[0];
                            rd_next = shift_reg[0];
                            if (shift_reg[7:1] != DEV_ADDR)
                            begin
                                state_next = TKP_IDLE;
                                oe_next = 1'b0;
                                rd_next = 1'b0;
                            end
                        end
                        else if (first_reg)
                        begin
                            ptr_next = shift_reg;
                            first_next = 1'b0;
                        end
                        else
                        begin
                            wr_next = 1'b1;
                            bump_next = 1'b1;
                        end
                    end
                end
                TKP_ACK:
                begin
                    if (fall)
                    begin
                        cnt_next = 4'h0;
                        if (rw_reg)
                        begin
                            state_next = TKP_READ;
                            shift_next = bus.rdata;
                            oe_next = ~bus.rdata[7];
                            ptr_next = ptr_reg + 8'h01;
                        end
                        else
                        begin
                            state_next = TKP_WRITE;
                            oe_next = 1'b0;
                            bump_next = 1'b0;
                            if (bump_reg)
                                ptr_next = ptr_reg + 8'h01;
                        end
                    end
                end
                TKP_READ:
                begin
                    if (fall)
                    begin
                        if (cnt_reg == 4'h7)
                        begin
                            state_next = TKP_RACK;
                            oe_next = 1'b0;
                            cnt_next = 4'h0;
                        end
                        else
                        begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                            cnt_next = cnt_reg + 4'h1;
                        end
                    end
                end
                TKP_RACK:
                begin
                    // master ack fetches the next byte ahead of the falling edge
                    if (rise)
                    begin
                        if (sda)
                            state_next = TKP_IDLE;
                        else
                        begin
                            rd_next = 1'b1;
                            bump_next = 1'b1;
                        end
                    end
                    else if (fall && bump_reg)
                    begin
                        state_next = TKP_READ;
                        shift_next = bus.rdata;
                        oe_next = ~bus.rdata[7];
                        ptr_next = ptr_reg + 8'h01;
                        bump_next = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_reg <= TKP_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            first_reg <= 1'b0;
            rw_reg <= 1'b0;
            bump_reg <= 1'b0;
            oe_reg <= 1'b0;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            first_reg <= first_next;
            rw_reg <= rw_next;
            bump_reg <= bump_next;
            oe_reg <= oe_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = oe_reg;
    assign bus.addr = ptr_reg;
    assign bus.wdata = shift_reg;
    assign bus.wr = wr_reg;
    assign bus.rd = rd_reg;
endmodule

// ---- logic/tkp_pkg.sv ----
package tkp_pkg;
    localparam int CH_COUNT = 24;
    localparam int DELTA_W = 8;
    localparam int IMP_W = 13;
    localparam logic [7:0] ADDR_CTRL = 8'h90;
    localparam logic [7:0] ADDR_MASK_LOW = 8'h92;
    localparam logic [7:0] ADDR_MASK_MID = 8'h93;
    localparam logic [7:0] ADDR_MASK_HIGH = 8'h94;
    localparam logic [7:0] ADDR_CFG = 8'h96;
    localparam logic [7:0] ADDR_TOUCH_THR = 8'h97;
    localparam logic [7:0] ADDR_ENV_THR = 8'h98;
    localparam logic [7:0] ADDR_FILT0 = 8'h9a;
    localparam logic [7:0] ADDR_FILT1 = 8'h9b;
    localparam logic [7:0] ADDR_FILT2 = 8'h9c;
    localparam logic [7:0] ADDR_PROX_LO = 8'hb0;
    localparam logic [7:0] ADDR_PROX_HI = 8'hb1;
    localparam logic [7:0] ADDR_RT0 = 8'hb4;
    localparam logic [7:0] ADDR_RT1 = 8'hb5;
    localparam logic [7:0] ADDR_RT2 = 8'hb6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CTRL_WR_MASK = 8'hf7;
    localparam logic [7:0] CFG_WR_MASK = 8'hdf;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CTRL_EN_BIT = 2;
    localparam int CFG_DITHER_LSB = 6;
    localparam int CFG_INTERVAL_LSB = 2;
    localparam int ENV_FORCE_BIT = 7;
    localparam logic [1:0] FILTER_NONE = 2'h0;
    localparam logic [1:0] ACCESS_DITHERED = 2'h0;
    localparam logic [1:0] ACCESS_CALIBRATED = 2'h1;
    localparam logic [5:0] DITHER_BASE = 6'h04;
    localparam logic [2:0] INTERVAL_MAX_CODE = 3'h4;
    localparam logic [4:0] INTERVAL_ONE = 5'h01;
    localparam logic [6:0] I2C_DEV_ADDR = 7'h5c;
    typedef enum {TKP_IDLE, TKP_ADDR, TKP_ACK, TKP_WRITE, TKP_READ, TKP_RACK} tkp_i2c_state_t;
endpackage

// ---- logic/tkp_regbus_if.sv ----
`timescale 1ns/1ps
interface tkp_regbus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    modport master (output addr, output wdata, output wr, output rd, input rdata);
    modport slave (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ---- verif/tkp_filter_prox_top_bench.sv ----
`timescale 1ns/1ps
module tkp_filter_prox_top_bench
    import tkp_pkg::*;
;
    logic clk, rst, scl, sda, so, oe, pv, pe;
    logic [12:0] ps;
    logic [191:0] dl;
    logic [7:0] tl, rl, got;
    logic [3:0] pc;
    logic [5:0] df;
    logic [31:0] seed;
    int error_cnt, compares;
    logic [7:0] exp_q[$];
    string nm_q[$];
    event got_ev;
    logic [7:0] rst_tab[9] = '{ADDR_MASK_MID, ADDR_MASK_HIGH, ADDR_CFG, ADDR_TOUCH_THR,
        ADDR_ENV_THR, ADDR_FILT0, ADDR_PROX_LO, ADDR_PROX_HI, ADDR_RT0};
    logic [7:0] rw_tab[3] = '{ADDR_MASK_MID, ADDR_MASK_HIGH, ADDR_TOUCH_THR};
    tkp_filter_prox_top i_dut(.clock_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(so), .sda_oe_out(oe), .channel_delta_in(dl), .touch_level_in(tl),
        .release_level_in(rl), .prox_sample_valid_in(pv), .prox_sample_in(ps),
        .prox_enable_out(pe), .prox_channel_out(pc), .dither_factor_out(df));
    tkp_i2c_host i_host(.clock_in(clk), .sda_oe_in(oe), .sda_val_in(so), .scl_out(scl), .sda_line_out(sda));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(string n, logic [7:0] s, logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic note(string n, logic [7:0] e, logic [7:0] s);
        nm_q.push_back(n);
        exp_q.push_back(e);
        got = s;
        -> got_ev;
        @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [8:0] q;
        i_host.start();
        i_host.xfer({I2C_DEV_ADDR, 2'b01}, q);
        i_host.xfer({a, 1'b1}, q);
        i_host.xfer({d, 1'b1}, q);
        i_host.stop();
    endtask
    task automatic rd(string n, logic [7:0] a, logic [7:0] e);
        logic [8:0] q, k;
        i_host.start();
        i_host.xfer({I2C_DEV_ADDR, 2'b01}, k);
        i_host.xfer({a, 1'b1}, q);
        i_host.start();
        i_host.xfer({I2C_DEV_ADDR, 2'b11}, q);
        i_host.xfer(9'h1ff, q);
        i_host.stop();
        note("ack", 8'h00, {7'h00, k[0]});
        note(n, e, q[8:1]);
    endtask
    task automatic pulse(logic [12:0] v);
        ps = v;
        pv = 1'b1;
        @(negedge clk);
        pv = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic complete_run();
        $display("comparisons %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // bounded run guards against a hung bus
    initial
    begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial
    begin
        forever
        begin
            @(got_ev);
            check(nm_q.pop_front(), got, exp_q.pop_front());
        end
    end
    // ==========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        pv = 1'b0;
        ps = 13'h0000;
        dl = '0;
        tl = 8'h10;
        rl = 8'h08;
        seed = 32'h74e3ee12;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        foreach (rst_tab[i]) rd("reset", rst_tab[i], 8'h00);
        note("dither", 8'h04, {2'h0, df});
        foreach (rw_tab[i])
        begin
            seed = lfsr(seed);
            wr(rw_tab[i], seed[7:0]);
            rd("rw", rw_tab[i], seed[7:0]);
        end
        wr(ADDR_CFG, seed[15:8]);
        rd("cfg", ADDR_CFG, seed[15:8] & CFG_WR_MASK);
        wr(ADDR_FILT0, 8'hff);
        rd("ro", ADDR_FILT0, 8'h00);
        rd("unmapped", 8'h91, 8'h00);
        $display("test registers done");
        for (int c = 0; c < 4; c++)
        begin
            wr(ADDR_CFG, 8'(c << 6));
            note("dither", 8'(4 << c), {2'h0, df});
        end
        $display("test dither done");
        dl[7:0] = 8'h14;
        dl[143:136] = 8'h1e;
        rd("rt0", ADDR_RT0, 8'h01);
        rd("rt2", ADDR_RT2, 8'h02);
        rd("flt0", ADDR_FILT0, 8'h01);
        rd("flt2", ADDR_FILT2, 8'h02);
        dl[7:0] = 8'h0c;
        rd("rt0", ADDR_RT0, 8'h01);
        dl[7:0] = 8'h04;
        rd("rt0", ADDR_RT0, 8'h00);
        dl[7:0] = 8'h14;
        $display("test touch done");
        wr(ADDR_MASK_LOW, 8'hff);
        wr(ADDR_MASK_MID, 8'hff);
        wr(ADDR_MASK_HIGH, 8'hff);
        wr(ADDR_CTRL, 8'h01);
        rd("flt0", ADDR_FILT0, 8'h00);
        rd("flt2", ADDR_FILT2, 8'h02);
        wr(ADDR_MASK_HIGH, 8'h00);
        rd("flt0", ADDR_FILT0, 8'h01);
        rd("flt2", ADDR_FILT2, 8'h02);
        wr(ADDR_MASK_HIGH, 8'hff);
        wr(ADDR_CTRL, 8'h02);
        rd("flt0", ADDR_FILT0, 8'h01);
        rd("flt2", ADDR_FILT2, 8'h02);
        $display("test filter done");
        wr(ADDR_CTRL, 8'h54);
        note("en", 8'h01, {7'h00, pe});
        note("sel", 8'h05, {4'h0, pc});
        wr(ADDR_TOUCH_THR, 8'h08);
        wr(ADDR_ENV_THR, 8'h03);
        wr(ADDR_CFG, 8'h00);
        pulse(13'h03e8);
        rd("plo", ADDR_PROX_LO, 8'he8);
        rd("phi", ADDR_PROX_HI, 8'h43);
        pulse(13'h0384);
        rd("phi", ADDR_PROX_HI, 8'hc3);
        wr(ADDR_CFG, 8'h01);
        rd("plo", ADDR_PROX_LO, 8'he8);
        wr(ADDR_ENV_THR, 8'h83);
        rd("plo", ADDR_PROX_LO, 8'h84);
        rd("phi", ADDR_PROX_HI, 8'hc3);
        wr(ADDR_ENV_THR, 8'h03);
        pulse(13'h0384);
        rd("phi", ADDR_PROX_HI, 8'h43);
        wr(ADDR_CTRL, 8'h00);
        pulse(13'h01f4);
        wr(ADDR_CFG, 8'h00);
        rd("plo", ADDR_PROX_LO, 8'h84);
        note("en", 8'h00, {7'h00, pe});
        $display("test proximity done");
        complete_run();
    end
endmodule

// ---- verif/tkp_i2c_host.sv ----
`timescale 1ns/1ps
// i2c host; sda is open drain, pulled up when nobody pulls low
module tkp_i2c_host
(
    input wire logic clock_in,
    input wire logic sda_oe_in,
    input wire logic sda_val_in,
    output logic scl_out,
    output logic sda_line_out
);
    logic sda_drv;
    assign sda_line_out = sda_drv & (sda_oe_in ? sda_val_in : 1'b1);
    initial
    begin
        scl_out = 1'b1;
        sda_drv = 1'b1;
    end
    // 5 clocks a phase, above the 4-clock minimum
    task automatic half();
        repeat (5) @(negedge clock_in);
    endtask
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl_out = 1'b0;
    endtask
    // eight data bits then the ack slot
    task automatic xfer(input logic [8:0] d, output logic [8:0] q);
        for (int i = 8; i >= 0; i--)
        begin
            sda_drv = d[i];
            half();
            scl_out = 1'b1;
            half();
            q[i] = sda_line_out;
            scl_out = 1'b0;
        end
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask
endmodule
